/* verilog/tlfr_pkg.sv */
// constants for the temperature limit and fault response block
package tlfr_pkg;
    // command codes of the held settings
    localparam logic [7:0] CMD_OT_WARN_THR = 8'h51;
    localparam logic [7:0] CMD_UT_WARN_THR = 8'h52;
    localparam logic [7:0] CMD_UT_FAULT_THR = 8'h53;
    localparam logic [7:0] CMD_UT_FAULT_ACT = 8'h54;
    // command code of the delay unit register, which lives outside this block
    localparam logic [7:0] CMD_DELAY_UNIT = 8'hC8;
    // reset values
    localparam logic [15:0] OT_WARN_THR_RST = 16'h0000;
    localparam logic [15:0] UT_WARN_THR_RST = 16'h0000;
    localparam logic [15:0] UT_FAULT_THR_RST = 16'h0000;
    localparam logic [7:0] UT_FAULT_ACT_RST = 8'h00;
    // fault action byte layout
    localparam int ACT_HI = 7;
    localparam int ACT_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int TIME_HI = 2;
    localparam int TIME_LO = 0;
    // action codes
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_DELAY_RETRY = 2'h1;
    localparam logic [1:0] ACT_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] ACT_RESUME_OK = 2'h3;
    // retry codes
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // linear numeric format layout
    localparam int LIN_EXP_HI = 15;
    localparam int LIN_EXP_LO = 11;
    localparam int LIN_MANT_HI = 10;
    localparam int LIN_MANT_LO = 0;
    localparam int LIN_BIAS = 16;
    localparam int FIX_W = 48;
    // widths
    localparam int UNIT_W = 16;
    localparam int TIMER_W = 24;
    // response states
    typedef enum logic [2:0] {
        TLFR_RUN,
        TLFR_DELAY,
        TLFR_OFF_WAIT,
        TLFR_HOLD,
        TLFR_LATCHED,
        TLFR_STOPPED
    } tlfr_state_t;
endpackage

/* verilog/tlfr_top.sv */
// temperature limits and under-temperature fault response engine
//
// Notes on behaviour
// - over-temperature warning threshold, 16 bits, linear format, at code 0x51
// - under-temperature warning threshold, 16 bits, linear format, at code 0x52
// - under-temperature fault threshold, 16 bits, linear format, at code 0x53
// - action byte at 0x54, bits 7:6; code 00 keeps the output running, though UT_FAULT is still raised
// - code 01 keeps running for the delay, then turns off and follows the retry setting if fault remains
// - code 10 disables output at once, then follows the retry setting
// - code 11 holds output off while fault lasts, resumes when gone
// - retry 000: no restart, output stays off until fault cleared
// - retry 001..110: that many restarts, then off until fault cleared
// - restart attempts start one programmed interval apart
// - retry 111 retries forever until commanded off, bias lost or other fault
// - bits 2:0 select two to the power field delay units
// - delay unit length comes from the separate register at 0xC8
`timescale 1ns/1ps
module tlfr_top
    import tlfr_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // command access by code
    input wire logic CMD_WR,
    input wire logic CMD_RD,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_WDATA,
    output logic [15:0] RSP_RDATA,
    output logic RSP_VALID,
    output logic RSP_ERR,
    // measurement and system state
    input wire logic [15:0] TEMP_READING,
    input wire logic [tlfr_pkg::UNIT_W-1:0] DELAY_UNIT_CYCLES,
    input wire logic OUTPUT_ON_CMD,
    input wire logic BIAS_OK,
    input wire logic OTHER_FAULT_OFF,
    input wire logic FAULT_CLEAR,
    // status and control out
    output logic OT_WARNING,
    output logic UT_WARNING,
    output logic UT_FAULT,
    output logic OUTPUT_ENABLE,
    output logic FAULT_LATCHED_OFF,
    output logic RETRY_ACTIVE
);
    import tlfr_pkg::*;

    logic [15:0] ot_warn_thr_reg;
    logic [15:0] ut_warn_thr_reg;
    logic [15:0] ut_fault_thr_reg;
    logic [7:0] ut_fault_act_reg;
    tlfr_state_t state_reg;
    tlfr_state_t state_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_next;
    logic [2:0] tries_reg;
    logic [2:0] tries_next;
    logic out_en_next;
    logic [1:0] act;
    logic [2:0] retry_code;
    logic [TIMER_W-1:0] interval;
    logic run_allowed;
    logic fault_now;
    logic ot_warn_now;
    logic ut_warn_now;
    logic signed [FIX_W-1:0] temp_fix;

    // the timer must hold 128 units of the widest delay unit
    if (TIMER_W < UNIT_W + 7) begin : g_timer_width
        $error("tlfr_top: delay timer narrower than the longest delay");
    end
    // the fixed point value must hold the largest mantissa at the largest exponent
    if (FIX_W < 42) begin : g_fix_width
        $error("tlfr_top: fixed point width too small for the linear compare");
    end

    // linear format to signed fixed point with LIN_BIAS fractional bits
    function automatic logic signed [FIX_W-1:0] lin_to_fix(input logic [15:0] v);
        logic signed [FIX_W-1:0] m;
        logic [5:0] sh;
        m = FIX_W'(signed'(v[LIN_MANT_HI:LIN_MANT_LO]));
        sh = 6'(signed'(v[LIN_EXP_HI:LIN_EXP_LO]) + LIN_BIAS);
        lin_to_fix = m <<< sh;
    endfunction

    // cycles in a delay of 2**field units, minus one for a count-down to zero
    function automatic logic [TIMER_W-1:0] delay_load(input logic [2:0] field,
                                                      input logic [UNIT_W-1:0] unit);
        logic [TIMER_W-1:0] cycles;
        cycles = TIMER_W'(unit) << field;
        if (cycles == '0) begin
            cycles = TIMER_W'(1);
        end
        delay_load = cycles - TIMER_W'(1);
    endfunction

    // where a fault sequence goes once the output has been switched off
    function automatic tlfr_state_t retry_entry(input logic [2:0] code);
        if (code == RETRY_NONE) begin
            retry_entry = TLFR_LATCHED;
        end else begin
            retry_entry = TLFR_OFF_WAIT;
        end
    endfunction

    // a failed attempt is the last one once a limited count is used up
    function automatic logic last_attempt(input logic [2:0] tries, input logic [2:0] code);
        last_attempt = (code != RETRY_FOREVER) && (tries + 3'h1 >= code);
    endfunction

    assign act = ut_fault_act_reg[ACT_HI:ACT_LO];
    assign retry_code = ut_fault_act_reg[RETRY_HI:RETRY_LO];
    assign interval = delay_load(ut_fault_act_reg[TIME_HI:TIME_LO], DELAY_UNIT_CYCLES);
    // retrying stops when commanded off, bias lost, or another fault shuts us down
    assign run_allowed = OUTPUT_ON_CMD & BIAS_OK & ~OTHER_FAULT_OFF;
    // the reading is decoded once and shared by all three comparisons
    assign temp_fix = lin_to_fix(TEMP_READING);
    // compare on the live reading so the response reacts without an extra cycle
    assign fault_now = temp_fix < lin_to_fix(ut_fault_thr_reg);
    // the compares are strict: a reading equal to a limit raises nothing
    assign ot_warn_now = temp_fix > lin_to_fix(ot_warn_thr_reg);
    assign ut_warn_now = temp_fix < lin_to_fix(ut_warn_thr_reg);

    // settings writes
    // a write to a code this block does not hold changes nothing here
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            ot_warn_thr_reg <= OT_WARN_THR_RST;
            ut_warn_thr_reg <= UT_WARN_THR_RST;
            ut_fault_thr_reg <= UT_FAULT_THR_RST;
            ut_fault_act_reg <= UT_FAULT_ACT_RST;
        end else if (CMD_WR) begin
            unique case (CMD_CODE)
                CMD_OT_WARN_THR: ot_warn_thr_reg <= CMD_WDATA;
                CMD_UT_WARN_THR: ut_warn_thr_reg <= CMD_WDATA;
                CMD_UT_FAULT_THR: ut_fault_thr_reg <= CMD_WDATA;
                CMD_UT_FAULT_ACT: ut_fault_act_reg <= CMD_WDATA[7:0];
                default: ;
            endcase
        end
    end

    // read answers and refusal of unknown codes, one cycle after the strobe
    // read data rests at zero between answers, so idle cycles carry no stale value
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            RSP_RDATA <= 16'h0000;
            RSP_VALID <= 1'b0;
            RSP_ERR <= 1'b0;
        end else begin
            RSP_VALID <= CMD_RD;
            RSP_ERR <= 1'b0;
            RSP_RDATA <= 16'h0000;
            if (CMD_RD) begin
                unique case (CMD_CODE)
                    CMD_OT_WARN_THR: RSP_RDATA <= ot_warn_thr_reg;
                    CMD_UT_WARN_THR: RSP_RDATA <= ut_warn_thr_reg;
                    CMD_UT_FAULT_THR: RSP_RDATA <= ut_fault_thr_reg;
                    CMD_UT_FAULT_ACT: RSP_RDATA <= {8'h00, ut_fault_act_reg};
                    default: RSP_ERR <= 1'b1;
                endcase
            end else if (CMD_WR) begin
                unique case (CMD_CODE)
                    CMD_OT_WARN_THR, CMD_UT_WARN_THR, CMD_UT_FAULT_THR, CMD_UT_FAULT_ACT: ;
                    default: RSP_ERR <= 1'b1;
                endcase
            end
        end
    end

    // limit comparisons
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            OT_WARNING <= 1'b0;
            UT_WARNING <= 1'b0;
            UT_FAULT <= 1'b0;
        end else begin
            OT_WARNING <= ot_warn_now;
            UT_WARNING <= ut_warn_now;
            UT_FAULT <= fault_now;
        end
    end

    // response sequencing
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        tries_next = tries_reg;
        out_en_next = 1'b1;
        unique case (state_reg)
            // running; a stop request outranks a fault, so no sequence starts while off
            TLFR_RUN: begin
                if (!run_allowed) begin
                    state_next = TLFR_STOPPED;
                    out_en_next = 1'b0;
                end else if (fault_now) begin
                    unique case (act)
                        ACT_IGNORE: state_next = TLFR_RUN;
                        ACT_DELAY_RETRY: begin
                            state_next = TLFR_DELAY;
                            timer_next = interval;
                        end
                        ACT_DISABLE_RETRY: begin
                            out_en_next = 1'b0;
                            tries_next = 3'h0;
                            timer_next = interval;
                            state_next = retry_entry(retry_code);
                        end
                        ACT_RESUME_OK: begin
                            out_en_next = 1'b0;
                            state_next = TLFR_HOLD;
                        end
                    endcase
                end
            end
            TLFR_DELAY: begin
                // output keeps running through the delay
                if (!run_allowed) begin
                    state_next = TLFR_STOPPED;
                    out_en_next = 1'b0;
                end else if (timer_reg != '0) begin
                    timer_next = timer_reg - TIMER_W'(1);
                end else if (!fault_now) begin
                    state_next = TLFR_RUN; // fault went away during the delay
                end else begin
                    out_en_next = 1'b0;
                    tries_next = 3'h0;
                    timer_next = interval;
                    state_next = retry_entry(retry_code);
                end
            end
            // output off between restart attempts
            TLFR_OFF_WAIT: begin
                out_en_next = 1'b0;
                if (!run_allowed) begin
                    state_next = TLFR_STOPPED;
                end else if (timer_reg != '0) begin
                    timer_next = timer_reg - TIMER_W'(1);
                end else if (!fault_now) begin
                    // the attempt is judged on the edge after the timer reaches zero
                    out_en_next = 1'b1; // restart attempt succeeds
                    state_next = TLFR_RUN;
                end else if (last_attempt(tries_reg, retry_code)) begin
                    state_next = TLFR_LATCHED;
                end else begin
                    // failed attempt; next one starts one interval later
                    tries_next = (retry_code == RETRY_FOREVER) ? tries_reg : tries_reg + 3'h1;
                    timer_next = interval;
                end
            end
            // output held off until the fault goes away by itself
            TLFR_HOLD: begin
                out_en_next = 1'b0;
                if (!run_allowed) begin
                    state_next = TLFR_STOPPED;
                end else if (!fault_now) begin
                    out_en_next = 1'b1;
                    state_next = TLFR_RUN;
                end
            end
            TLFR_LATCHED: begin
                out_en_next = 1'b0;
                // a clear with the fault still present does not release the latch
                if (FAULT_CLEAR && !fault_now && run_allowed) begin
                    out_en_next = 1'b1;
                    state_next = TLFR_RUN;
                end else if (!run_allowed) begin
                    state_next = TLFR_STOPPED;
                end
            end
            // commanded off; coming back starts fresh, any earlier latch is forgotten
            TLFR_STOPPED: begin
                out_en_next = 1'b0;
                if (run_allowed) begin
                    out_en_next = 1'b1;
                    state_next = TLFR_RUN;
                end
            end
            // an illegal state code parks the output off until run is granted
            default: begin
                out_en_next = 1'b0;
                state_next = TLFR_STOPPED;
            end
        endcase
    end

    // response state registers
    // the status flags follow the next state so they line up with OUTPUT_ENABLE
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            state_reg <= TLFR_STOPPED;
            timer_reg <= '0;
            tries_reg <= 3'h0;
            OUTPUT_ENABLE <= 1'b0;
            FAULT_LATCHED_OFF <= 1'b0;
            RETRY_ACTIVE <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            tries_reg <= tries_next;
            OUTPUT_ENABLE <= out_en_next;
            FAULT_LATCHED_OFF <= state_next == TLFR_LATCHED;
            RETRY_ACTIVE <= state_next == TLFR_OFF_WAIT;
        end
    end
endmodule

/* test/tlfr_top_props.sv */
// port assertions for the temperature fault response block
`timescale 1ns/1ps
module tlfr_props (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // command port
    input wire logic CMD_WR,
    input wire logic CMD_RD,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] RSP_RDATA,
    input wire logic RSP_VALID,
    input wire logic RSP_ERR,
    // system state and response
    input wire logic OUTPUT_ON_CMD,
    input wire logic BIAS_OK,
    input wire logic OTHER_FAULT_OFF,
    input wire logic FAULT_CLEAR,
    input wire logic OUTPUT_ENABLE,
    input wire logic FAULT_LATCHED_OFF,
    input wire logic RETRY_ACTIVE
);
    // run permission and the four held codes
    wire run = OUTPUT_ON_CMD & BIAS_OK & ~OTHER_FAULT_OFF;
    wire known = (CMD_CODE >= 8'h51) && (CMD_CODE <= 8'h54);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    chk_read_answer: assert property (CMD_RD |=> RSP_VALID) else $error("read not answered");
    chk_rdata_quiet: assert property (!RSP_VALID |-> RSP_RDATA == 16'h0000) else $error("read data not quiet");
    chk_bad_code: assert property ((CMD_WR || CMD_RD) && !known |=> RSP_ERR) else $error("no error answer");
    chk_good_code: assert property ((CMD_WR || CMD_RD) && known |=> !RSP_ERR) else $error("false error");
    chk_stop_output: assert property (!run |=> !OUTPUT_ENABLE && !RETRY_ACTIVE) else $error("runs while off");
    chk_rise_needs_run: assert property ($rose(OUTPUT_ENABLE) |-> $past(run)) else $error("start without run");
    chk_latch_dark: assert property (FAULT_LATCHED_OFF |-> !OUTPUT_ENABLE && !RETRY_ACTIVE) else $error("latch lit");
    chk_latch_holds: assert property (FAULT_LATCHED_OFF && run && !FAULT_CLEAR |=> FAULT_LATCHED_OFF)
        else $error("latch dropped");
endmodule
bind tlfr_top tlfr_props u_tlfr_props (.REF_CLK, .RESETN, .CMD_WR, .CMD_RD, .CMD_CODE, .RSP_RDATA, .RSP_VALID,
    .RSP_ERR, .OUTPUT_ON_CMD, .BIAS_OK, .OTHER_FAULT_OFF, .FAULT_CLEAR, .OUTPUT_ENABLE, .FAULT_LATCHED_OFF,
    .RETRY_ACTIVE);

/* test/tlfr_host.sv */
// host model that configures the block through its command port
`timescale 1ns/1ps
module tlfr_host (
    // clock
    input wire logic REF_CLK,
    // command port
    output logic CMD_WR,
    output logic CMD_RD,
    output logic [7:0] CMD_CODE,
    output logic [15:0] CMD_WDATA
);
    // idle port at time zero
    initial begin
        CMD_WR = 1'b0;
        CMD_RD = 1'b0;
        CMD_CODE = 8'h00;
        CMD_WDATA = 16'h0000;
    end
    // one access per two cycles; released strobes drop to zero and code and data are inverted so no stale value lingers
    task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] data);
        @(negedge REF_CLK);
        CMD_WR = wr;
        CMD_RD = !wr;
        CMD_CODE = code;
        CMD_WDATA = data;
        @(negedge REF_CLK);
        CMD_WR = 1'b0;
        CMD_RD = 1'b0;
        CMD_CODE = ~code;
        CMD_WDATA = ~data;
    endtask
endmodule

/* test/tlfr_top_tb.sv */
// self-checking bench for the temperature fault response block
`timescale 1ns/1ps
module tlfr_top_tb;
    import tlfr_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, on_cmd = 1'b1, bias_ok = 1'b1, other_off = 1'b0, clr = 1'b0;
    logic wr, rd_s, rsp_valid, rsp_err, ot_w, ut_w, ut_f, out_en, latched, retry_act;
    logic [7:0] code;
    logic [15:0] wdata, rdata, temp = 16'h0032;
    logic [UNIT_W-1:0] unit = 16'h0002;
    logic [16:0] exp_q[$];
    logic [31:0] seed = 32'hE8DA92C3;
    logic [15:0] tv[4] = '{16'hF8CA, 16'hF8C8, 16'h0019, 16'h000A};
    logic [2:0] ev[4] = '{3'b100, 3'b000, 3'b010, 3'b011};
    int bad_count = 0;
    int num_checks = 0;
    // 50 MHz clock
    always #10 clk = ~clk;
    tlfr_top u_tlfr_top (.REF_CLK(clk), .RESETN(resetn), .CMD_WR(wr), .CMD_RD(rd_s), .CMD_CODE(code),
        .CMD_WDATA(wdata), .RSP_RDATA(rdata), .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err), .TEMP_READING(temp),
        .DELAY_UNIT_CYCLES(unit), .OUTPUT_ON_CMD(on_cmd), .BIAS_OK(bias_ok), .OTHER_FAULT_OFF(other_off),
        .FAULT_CLEAR(clr), .OT_WARNING(ot_w), .UT_WARNING(ut_w), .UT_FAULT(ut_f), .OUTPUT_ENABLE(out_en),
        .FAULT_LATCHED_OFF(latched), .RETRY_ACTIVE(retry_act));
    tlfr_host u_tlfr_host (.REF_CLK(clk), .CMD_WR(wr), .CMD_RD(rd_s), .CMD_CODE(code), .CMD_WDATA(wdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [16:0] seen, input logic [16:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] c, input logic [16:0] e);
        exp_q.push_back(e);
        u_tlfr_host.acc(1'b0, c, 16'h0000);
    endtask
    // bounded wait on output enable or the latch; n counts the falling edges passed
    task automatic wait_for(input logic lat, input logic v, output int n);
        n = 0;
        while (((lat ? latched : out_en) !== v) && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    // warm up, clear any latch, load a new fault action byte, then wait until running
    task automatic cfg(input logic [7:0] act);
        int m;
        temp = 16'h0032;
        clr = 1'b1;
        u_tlfr_host.acc(1'b1, CMD_UT_FAULT_ACT, {8'h00, act});
        clr = 1'b0;
        repeat (3) @(negedge clk);
        wait_for(1'b0, 1'b1, m);
    endtask
    // answer monitor: every read answer or error pulse is matched against the oldest note
    always @(negedge clk) begin
        if (rsp_valid === 1'b1 || rsp_err === 1'b1) begin
            chk({rsp_err, rdata}, exp_q.size() > 0 ? exp_q.pop_front() : 17'h1FFFF);
        end
    end
    // main sequence
    initial begin
        int n;
        int t;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(8'h51 + 8'(i), 17'h00000);
            seed = lfsr(seed);
            u_tlfr_host.acc(1'b1, 8'h51 + 8'(i), seed[15:0]);
            rd(8'h51 + 8'(i), {1'b0, (i == 3) ? {8'h00, seed[7:0]} : seed[15:0]});
        end
        // the delay unit register lives outside, so a write there is refused too
        exp_q.push_back(17'h10000);
        u_tlfr_host.acc(1'b1, CMD_DELAY_UNIT, 16'hFFFF);
        rd(CMD_DELAY_UNIT, 17'h10000);
        u_tlfr_host.acc(1'b1, CMD_OT_WARN_THR, 16'h0064);
        u_tlfr_host.acc(1'b1, CMD_UT_WARN_THR, 16'h001E);
        u_tlfr_host.acc(1'b1, CMD_UT_FAULT_THR, 16'h0014);
        // limits in linear format, fault ignored
        cfg(8'h00);
        for (int i = 0; i < 4; i++) begin
            temp = tv[i];
            repeat (3) @(negedge clk);
            chk({ot_w, ut_w, ut_f, out_en}, {ev[i], 1'b1});
        end
        // off while cold, back on when warm
        cfg(8'hC0);
        temp = 16'h000A;
        wait_for(1'b0, 1'b0, n);
        chk(latched, 1'b0);
        temp = 16'h0032;
        wait_for(1'b0, 1'b1, n);
        chk(n <= 3, 1'b1);
        // disable then a counted number of spaced restarts before latching
        for (int r = 1; r < 7; r++) begin
            t = (r == 6) ? 7 : r % 3;
            cfg({2'b10, 3'(r), 3'(t)});
            temp = 16'h000A;
            wait_for(1'b0, 1'b0, n);
            chk(retry_act, 1'b1);
            wait_for(1'b1, 1'b1, n);
            // attempts are one interval of unit times two to the field apart
            chk(17'(n), 17'(r * (int'(unit) << t)));
        end
        clr = 1'b1;
        repeat (2) @(negedge clk);
        clr = 1'b0;
        chk(latched, 1'b1);
        // endless retry, stopped by each shutdown cause in turn
        cfg(8'hB8);
        temp = 16'h000A;
        wait_for(1'b0, 1'b0, n);
        repeat (40) @(negedge clk);
        chk(latched, 1'b0);
        for (int k = 0; k < 3; k++) begin
            chk(retry_act, 1'b1);
            {on_cmd, bias_ok, other_off} = 3'b110 ^ (3'b100 >> k);
            repeat (2) @(negedge clk);
            chk({out_en, retry_act}, 2'b00);
            {on_cmd, bias_ok, other_off} = 3'b110;
            repeat (4) @(negedge clk);
        end
        temp = 16'h0032;
        wait_for(1'b0, 1'b1, n);
        chk(n <= 5, 1'b1);
        // run on for the delay with a longer unit, then latch with no retry, then clear
        unit = 16'h0003;
        cfg(8'h41);
        temp = 16'h000A;
        wait_for(1'b0, 1'b0, n);
        chk(17'(n), 17'((int'(unit) << 1) + 1));
        wait_for(1'b1, 1'b1, n);
        chk(n <= 1, 1'b1);
        temp = 16'h0032;
        clr = 1'b1;
        wait_for(1'b0, 1'b1, n);
        clr = 1'b0;
        chk(latched, 1'b0);
        chk(17'(exp_q.size()), 17'h00000);
        tally_and_finish();
    end
endmodule
